// File: tb/tas_chk.sv
`timescale 1ns/1ps
module tas_chk #(
  parameter int unsigned LOGO_COUNT = 20,
  parameter int unsigned QUAL_COUNT = 50
) (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire tas_pkg::tas_mode_e mode,
  input wire tas_pkg::tas_thr_s  thr,
  input wire tas_pkg::tas_meas_t level_pct,
  input wire tas_pkg::tas_meas_t temp_c,
  input wire logic               btn_ack_pin,
  input wire logic               btn_alt_pin,
  input wire logic               probe_ok_pin,
  input wire logic               equip_err_pin,
  input wire tas_pkg::tas_disp_s disp,
  input wire logic               buzzer,
  input wire logic               alarm_lamp,
  input wire logic               alarm_relay,
  input wire logic               control_relay
);
  tas_pkg::tas_meas_t lo_clr;
  tas_pkg::tas_meas_t hi_clr;
  tas_pkg::tas_meas_t ht_clr;
  logic               lvl_mode;
  assign lo_clr = thr.low_level_alarm_threshold + tas_pkg::HYST;
  assign hi_clr = thr.upper_control_threshold - tas_pkg::HYST;
  assign ht_clr = thr.high_temp_alarm_threshold - tas_pkg::HYST;
  assign lvl_mode = mode != tas_pkg::TAS_MODE_TEMP_CTRL;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_press;
    $rose(btn_ack_pin) && !btn_alt_pin && alarm_lamp;
  endsequence
  sequence s_hold;
    (btn_ack_pin && !btn_alt_pin) [*3];
  endsequence
  chk_reset_logo: assert property ($rose(rst_n) |-> (disp.screen == tas_pkg::TAS_SCR_LOGO) [*8])
    else $error("logo not held after reset");
  chk_level_bar: assert property (disp.screen == tas_pkg::TAS_SCR_BAR && $past(lvl_mode)
    |-> disp.bar[0] == ($past(level_pct) >= 10'sd10) && disp.bar[9] == ($past(level_pct) >= 10'sd100))
    else $error("level bar wrong");
  chk_alarm_set: assert property ($rose(alarm_lamp) |-> buzzer && disp.arrow)
    else $error("lamp without buzzer or arrow");
  chk_ack_silence: assert property (s_press ##1 s_hold |-> ##[0:1] !buzzer)
    else $error("ack did not silence buzzer");
  chk_level_clear: assert property (alarm_lamp && lvl_mode && level_pct > lo_clr
    && level_pct < hi_clr |=> !alarm_lamp)
    else $error("level alarm not cleared");
  chk_range_fault: assert property ((lvl_mode && (level_pct > 10'sd106 || level_pct < 10'sd0)
    && probe_ok_pin && !equip_err_pin && !btn_alt_pin && disp.screen != tas_pkg::TAS_SCR_LOGO) [*4]
    |=> disp.screen == tas_pkg::TAS_SCR_ERR_MEAS)
    else $error("range fault not shown");
  chk_equip_relay: assert property (equip_err_pin [*4] |-> !alarm_relay && !control_relay)
    else $error("relay on during equipment error");
  chk_param_view: assert property ((btn_ack_pin && btn_alt_pin
    && disp.screen != tas_pkg::TAS_SCR_LOGO) [*4]
    |=> disp.screen == tas_pkg::TAS_SCR_PARAM && disp.mode == $past(mode))
    else $error("parameter view missing");
  chk_temp_clear: assert property (alarm_lamp && !lvl_mode && temp_c < ht_clr
    && level_pct > lo_clr && level_pct < hi_clr |=> !alarm_lamp)
    else $error("temperature alarm not cleared");
  chk_ctrl_off: assert property (level_pct >= thr.upper_control_threshold |=> !control_relay)
    else $error("control relay on above upper threshold");
endmodule

bind tas_supervisor tas_chk #(.LOGO_COUNT(LOGO_COUNT), .QUAL_COUNT(QUAL_COUNT)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .mode(mode), .thr(thr), .level_pct(level_pct),
  .temp_c(temp_c), .btn_ack_pin(btn_ack_pin), .btn_alt_pin(btn_alt_pin),
  .probe_ok_pin(probe_ok_pin), .equip_err_pin(equip_err_pin), .disp(disp), .buzzer(buzzer),
  .alarm_lamp(alarm_lamp), .alarm_relay(alarm_relay), .control_relay(control_relay));

// File: tb/tas_panel_model.sv
`timescale 1ns/1ps
module tas_panel_model (
  input  wire logic sys_clk,
  input  wire logic ack_req,
  input  wire logic alt_req,
  input  wire logic probe_cut,
  output logic      btn_ack_pin,
  output logic      btn_alt_pin,
  output logic      probe_ok_pin
);
  // buttons idle released, probe plugged in until told otherwise
  initial begin
    btn_ack_pin  = 1'b0;
    btn_alt_pin  = 1'b0;
    probe_ok_pin = 1'b1;
  end
  always @(posedge sys_clk) begin
    btn_ack_pin  <= ack_req;
    btn_alt_pin  <= alt_req;
    probe_ok_pin <= !probe_cut;
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic               sys_clk, rst_n, unit_f, ack_req, alt_req, probe_cut;
  logic               equip_err_pin, temp_elec_err_pin, btn_ack_pin, btn_alt_pin;
  logic               probe_ok_pin, buzzer, alarm_lamp, alarm_relay, control_relay;
  tas_pkg::tas_mode_e mode;
  tas_pkg::tas_thr_s  thr;
  tas_pkg::tas_meas_t level_pct, temp_c, v;
  tas_pkg::tas_disp_s disp;
  int                 fail_count, checks_done, cyc_cnt;
  tas_pkg::tas_meas_t corner [4] = '{10'sd9, 10'sd10, 10'sd99, 10'sd100};
  tas_pkg::tas_meas_t rng_v [4] = '{10'sd106, 10'sd107, 10'sd0, -10'sd1};
  tas_pkg::tas_mode_e modes [3] = '{tas_pkg::TAS_MODE_LEVEL, tas_pkg::TAS_MODE_LEVEL_CTRL,
                                    tas_pkg::TAS_MODE_TEMP_CTRL};
  // short counts keep the run small; expectations below assume 20 and 50
  tas_supervisor #(.LOGO_COUNT(20), .QUAL_COUNT(50)) u_tas_supervisor (
    .sys_clk(sys_clk), .rst_n(rst_n), .mode(mode), .unit_f(unit_f), .thr(thr),
    .level_pct(level_pct), .temp_c(temp_c), .btn_ack_pin(btn_ack_pin),
    .btn_alt_pin(btn_alt_pin), .probe_ok_pin(probe_ok_pin), .equip_err_pin(equip_err_pin),
    .temp_elec_err_pin(temp_elec_err_pin), .disp(disp), .buzzer(buzzer),
    .alarm_lamp(alarm_lamp), .alarm_relay(alarm_relay), .control_relay(control_relay));
  tas_panel_model u_tas_panel_model (
    .sys_clk(sys_clk), .ack_req(ack_req), .alt_req(alt_req), .probe_cut(probe_cut),
    .btn_ack_pin(btn_ack_pin), .btn_alt_pin(btn_alt_pin), .probe_ok_pin(probe_ok_pin));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      fail_count++;
      test_done();
    end
  end
  task look(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // held past the two-flop synchroniser so the press is seen as one event
  task ack();
    ack_req <= 1'b1;
    look(6);
    ack_req <= 1'b0;
    look(1);
  endtask
  function automatic logic [9:0] bar_exp(input tas_pkg::tas_meas_t l, input int base,
                                         input int step);
    for (int i = 0; i < 10; i++) begin
      bar_exp[i] = l >= base + step * i;
    end
  endfunction
  // parameter view lists alarm thresholds, plus control levels where the mode has them
  function automatic logic [4:0] show_exp(input tas_pkg::tas_mode_e m);
    logic [4:0] ctl;
    ctl = tas_pkg::SHOW_UPPER_CTRL | tas_pkg::SHOW_LOWER_CTRL;
    if (m == tas_pkg::TAS_MODE_TEMP_CTRL) begin
      return tas_pkg::SHOW_TEMP_ALARM | ctl;
    end
    return tas_pkg::SHOW_LOW_ALARM | tas_pkg::SHOW_HIGH_ALARM |
           ((m == tas_pkg::TAS_MODE_LEVEL) ? 5'h00 : ctl);
  endfunction
  function automatic tas_pkg::tas_meas_t f_exp(input tas_pkg::tas_meas_t c);
    return tas_pkg::tas_meas_t'(int'(c) * 9 / 5 + 32);
  endfunction
  initial begin
    rst_n = 1'b0;
    mode = tas_pkg::TAS_MODE_LEVEL_CTRL;
    unit_f = 1'b0;
    thr = '{10'sd20, 10'sd90, 10'sd80, 10'sd30, -10'sd150};
    level_pct = 10'sd50;
    temp_c = -10'sd190;
    {ack_req, alt_req, probe_cut, equip_err_pin, temp_elec_err_pin} = 5'h00;
    {fail_count, checks_done, cyc_cnt} = '0;
    void'($urandom(32'hf4e8));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    look(17);
    chk(disp.screen, tas_pkg::TAS_SCR_LOGO);
    look(8);
    chk(disp.screen, tas_pkg::TAS_SCR_BAR);
    for (int i = 0; i < 12; i++) begin
      v = (i < 4) ? corner[i] : tas_pkg::tas_meas_t'($urandom_range(106, 0));
      level_pct <= v;
      look(2);
      chk(disp.bar, bar_exp(v, tas_pkg::BAR_BASE_PCT, tas_pkg::BAR_STEP_PCT));
    end
    level_pct <= 10'sd10;
    look(30);
    chk({alarm_lamp, control_relay}, 2'h1);
    level_pct <= 10'sd50;
    look(3);
    level_pct <= 10'sd10;
    look(40);
    chk(alarm_lamp, 1'b0);
    look(20);
    chk({alarm_lamp, buzzer, disp.arrow, alarm_relay}, 4'hf);
    ack();
    chk({alarm_lamp, buzzer, alarm_relay}, 3'h5);
    equip_err_pin <= 1'b1;
    look(5);
    chk({alarm_relay, control_relay}, 2'h0);
    equip_err_pin <= 1'b0;
    level_pct <= 10'sd22;
    look(6);
    chk({alarm_lamp, control_relay}, 2'h3);
    level_pct <= 10'sd23;
    look(2);
    chk({alarm_lamp, disp.arrow, alarm_relay}, 3'h0);
    level_pct <= 10'sd80;
    look(2);
    chk(control_relay, 1'b0);
    level_pct <= 10'sd90;
    look(60);
    chk({alarm_lamp, buzzer, disp.arrow}, 3'h7);
    level_pct <= 10'sd78;
    look(2);
    chk(alarm_lamp, 1'b1);
    level_pct <= 10'sd77;
    look(2);
    chk({alarm_lamp, control_relay}, 2'h0);
    for (int i = 0; i < 4; i++) begin
      level_pct <= rng_v[i];
      look(5);
      chk(disp.screen, i[0] ? tas_pkg::TAS_SCR_ERR_MEAS : tas_pkg::TAS_SCR_BAR);
    end
    level_pct <= 10'sd50;
    look(2);
    chk(disp.screen, tas_pkg::TAS_SCR_BAR);
    probe_cut <= 1'b1;
    look(5);
    chk({disp.screen, buzzer}, 4'h5);
    ack();
    chk({disp.screen, buzzer}, 4'h4);
    probe_cut <= 1'b0;
    look(5);
    chk(disp.screen, tas_pkg::TAS_SCR_BAR);
    foreach (modes[i]) begin
      mode <= modes[i];
      {ack_req, alt_req} <= 2'h3;
      look(6);
      chk({disp.screen, disp.mode}, {tas_pkg::TAS_SCR_PARAM, modes[i]});
      chk(disp.show, show_exp(modes[i]));
      {ack_req, alt_req} <= 2'h0;
      look(4);
      chk(disp.show, 5'h00);
    end
    temp_c <= -10'sd140;
    look(2);
    chk({disp.unit_f, disp.value}, {1'b0, -10'sd140});
    chk(disp.bar, bar_exp(-10'sd140, tas_pkg::TEMP_MIN_C + tas_pkg::TEMP_BAR_STEP_C,
                          tas_pkg::TEMP_BAR_STEP_C));
    unit_f <= 1'b1;
    look(2);
    chk({disp.unit_f, disp.value}, {1'b1, f_exp(-10'sd140)});
    look(60);
    chk({alarm_lamp, buzzer, disp.arrow}, 3'h7);
    ack();
    chk({alarm_lamp, buzzer, alarm_relay}, 3'h5);
    temp_c <= -10'sd152;
    look(2);
    chk(alarm_lamp, 1'b1);
    temp_c <= -10'sd153;
    look(2);
    chk({alarm_lamp, disp.arrow}, 2'h0);
    temp_c <= 10'sd51;
    look(2);
    chk(disp.screen, tas_pkg::TAS_SCR_ERR_MEAS);
    temp_c <= -10'sd201;
    look(2);
    chk(disp.screen, tas_pkg::TAS_SCR_ERR_MEAS);
    temp_c <= -10'sd190;
    temp_elec_err_pin <= 1'b1;
    look(5);
    chk(disp.screen, tas_pkg::TAS_SCR_ERR_INT);
    temp_elec_err_pin <= 1'b0;
    look(5);
    chk(disp.screen, tas_pkg::TAS_SCR_BAR);
    test_done();
  end
endmodule

// File: verilog/tas_pkg.sv
// Summary of operation
// - after reset a start-up logo is shown for about four seconds before normal display starts.
// - in level operation the level is a bar with graduations from 10 in steps of 10 percent.
// - a level below the low alarm threshold, or at/above the high one, for 30 s raises buzzer, lamp and arrow.
// - a button press during a level alarm silences the buzzer only; the alarm relay follows the condition.
// - a level alarm clears once the level is clearly above the low threshold or clearly below the upper control level.
// - a level below 0 or above 106 percent shows the measurement-range fault.
// - a disconnected or faulty probe shows the probe fault.
// - an internal equipment error de-energises every relay output.
// - a button press during a fault silences the buzzer; the fault stays shown until measurement is normal again.
// - holding both buttons shows the operating mode and the thresholds relevant to it.
// - in temperature operation the temperature is a bar shown in Celsius or Fahrenheit as configured.
// - a temperature at/above the high temperature threshold for 30 s raises buzzer, lamp and arrow.
// - acknowledging a temperature alarm silences only the buzzer; it clears once clearly below the threshold.
// - a temperature below -200 C or above +50 C shows the measurement-range fault at once.
// - a failure of the temperature electronics shows the internal fault.
// - the control thresholds drive the control relay; the alarm thresholds drive lamp and buzzer.
package tas_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned LOGO_MS         = 4000;
  localparam int unsigned QUAL_MS         = 30000;
  localparam int unsigned LOGO_CYC        = CLK_HZ / 1000 * LOGO_MS;
  localparam int unsigned QUAL_CYC        = CLK_HZ / 1000 * QUAL_MS;

  typedef logic signed [9:0] tas_meas_t;

  localparam tas_meas_t   LEVEL_MIN_PCT   = 10'sd0;
  localparam tas_meas_t   LEVEL_MAX_PCT   = 10'sd106;
  localparam tas_meas_t   TEMP_MIN_C      = -10'sd200;
  localparam tas_meas_t   TEMP_MAX_C      = 10'sd50;
  localparam tas_meas_t   BAR_BASE_PCT    = 10'sd10;
  localparam tas_meas_t   BAR_STEP_PCT    = 10'sd10;
  localparam tas_meas_t   TEMP_BAR_STEP_C = 10'sd25;
  localparam tas_meas_t   HYST            = 10'sd2;
  localparam int unsigned BAR_SEGS        = 10;

  localparam logic [4:0]  SHOW_LOW_ALARM  = 5'h01;
  localparam logic [4:0]  SHOW_HIGH_ALARM = 5'h02;
  localparam logic [4:0]  SHOW_UPPER_CTRL = 5'h04;
  localparam logic [4:0]  SHOW_LOWER_CTRL = 5'h08;
  localparam logic [4:0]  SHOW_TEMP_ALARM = 5'h10;

  typedef enum logic [1:0] {
    TAS_MODE_LEVEL      = 2'h0,
    TAS_MODE_LEVEL_CTRL = 2'h1,
    TAS_MODE_TEMP_CTRL  = 2'h3
  } tas_mode_e;

  typedef enum logic [2:0] {
    TAS_SCR_LOGO      = 3'h0,
    TAS_SCR_BAR       = 3'h1,
    TAS_SCR_PARAM     = 3'h3,
    TAS_SCR_ERR_PROBE = 3'h2,
    TAS_SCR_ERR_MEAS  = 3'h6,
    TAS_SCR_ERR_INT   = 3'h7
  } tas_screen_e;

  typedef struct packed {
    tas_meas_t low_level_alarm_threshold;
    tas_meas_t high_level_alarm_threshold;
    tas_meas_t upper_control_threshold;
    tas_meas_t lower_control_threshold;
    tas_meas_t high_temp_alarm_threshold;
  } tas_thr_s;

  typedef struct packed {
    tas_screen_e          screen;
    tas_mode_e            mode;
    logic [BAR_SEGS-1:0]  bar;
    tas_meas_t            value;
    logic                 unit_f;
    logic                 arrow;
    logic [4:0]           show;
  } tas_disp_s;

endpackage

// File: verilog/tas_qual_timer.sv
`timescale 1ns/1ps
module tas_qual_timer #(
  parameter int unsigned CNT_W = 32,
  parameter int unsigned COUNT = 1
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             done_q;
  logic             done_d;

  if (COUNT < 1 || CNT_W > 32 || (CNT_W < 32 && COUNT > (1 << CNT_W))) begin : g_bad_cfg
    $error("tas_qual_timer: COUNT does not fit CNT_W");
  end

  // dropping run restarts the count, so only a sustained run reaches done
  always_comb begin
    cnt_d  = '0;
    done_d = 1'b0;
    if (run) begin
      if (done_q || cnt_q == CNT_W'(COUNT - 1)) begin
        done_d = 1'b1;
        cnt_d  = cnt_q;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule

// File: verilog/tas_supervisor.sv
`timescale 1ns/1ps
module tas_supervisor #(
  parameter int unsigned LOGO_COUNT = tas_pkg::LOGO_CYC,
  parameter int unsigned QUAL_COUNT = tas_pkg::QUAL_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire tas_pkg::tas_mode_e  mode,
  input  wire logic                unit_f,
  input  wire tas_pkg::tas_thr_s   thr,
  input  wire tas_pkg::tas_meas_t  level_pct,
  input  wire tas_pkg::tas_meas_t  temp_c,
  input  wire logic                btn_ack_pin,
  input  wire logic                btn_alt_pin,
  input  wire logic                probe_ok_pin,
  input  wire logic                equip_err_pin,
  input  wire logic                temp_elec_err_pin,
  output tas_pkg::tas_disp_s       disp,
  output logic                     buzzer,
  output logic                     alarm_lamp,
  output logic                     alarm_relay,
  output logic                     control_relay
);

  localparam int unsigned NSYNC = 5;

  if (LOGO_COUNT < 1 || QUAL_COUNT < 1) begin : g_bad_count
    $error("tas_supervisor: timer counts must be at least one");
  end

  function automatic logic [tas_pkg::BAR_SEGS-1:0] bar_fill(
    input tas_pkg::tas_meas_t v,
    input tas_pkg::tas_meas_t base,
    input tas_pkg::tas_meas_t step
  );
    logic [tas_pkg::BAR_SEGS-1:0] b;
    b = '0;
    for (int i = 0; i < tas_pkg::BAR_SEGS; i++) begin
      b[i] = int'(v) >= int'(base) + int'(step) * i;
    end
    return b;
  endfunction

  function automatic tas_pkg::tas_meas_t to_fahrenheit(input tas_pkg::tas_meas_t c);
    int f;
    f = int'(c) * 9 / 5 + 32;
    return f[9:0];
  endfunction

  // pin synchronisers; stage one is read only by stage two
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] pins;

  assign pins = {temp_elec_err_pin, equip_err_pin, probe_ok_pin, btn_alt_pin, btn_ack_pin};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  logic ack_held;
  logic alt_held;
  logic probe_ok;
  logic equip_err;
  logic temp_elec_err;

  assign ack_held      = sync2_q[0];
  assign alt_held      = sync2_q[1];
  assign probe_ok      = sync2_q[2];
  assign equip_err     = sync2_q[3];
  assign temp_elec_err = sync2_q[4];

  // measurement classification
  logic is_temp;
  logic has_ctrl;
  logic probe_fault;
  logic range_fault;
  logic int_fault;
  logic any_fault;
  logic lvl_low;
  logic lvl_high;
  logic tmp_high;

  assign is_temp     = mode == tas_pkg::TAS_MODE_TEMP_CTRL;
  assign has_ctrl    = mode != tas_pkg::TAS_MODE_LEVEL;
  assign probe_fault = !probe_ok;
  assign range_fault = is_temp ? (temp_c < tas_pkg::TEMP_MIN_C || temp_c > tas_pkg::TEMP_MAX_C)
                               : (level_pct < tas_pkg::LEVEL_MIN_PCT ||
                                  level_pct > tas_pkg::LEVEL_MAX_PCT);
  assign int_fault   = equip_err || (is_temp && temp_elec_err);
  assign any_fault   = probe_fault || range_fault || int_fault;
  assign lvl_low     = level_pct < thr.low_level_alarm_threshold;
  assign lvl_high    = level_pct >= thr.high_level_alarm_threshold;
  assign tmp_high    = is_temp && temp_c >= thr.high_temp_alarm_threshold;

  // qualification timers
  logic logo_done;
  logic lvl_qual;
  logic tmp_qual;
  logic lvl_alarm_q;
  logic lvl_alarm_d;
  logic lvl_alarm_low_q;
  logic lvl_alarm_low_d;
  logic tmp_alarm_q;
  logic tmp_alarm_d;

  tas_qual_timer #(
    .CNT_W (32),
    .COUNT (LOGO_COUNT)
  ) u_logo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (1'b1),
    .done    (logo_done)
  );

  // a faulted measurement cannot qualify an alarm
  tas_qual_timer #(
    .CNT_W (32),
    .COUNT (QUAL_COUNT)
  ) u_lvl_qual (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (logo_done && !any_fault && !lvl_alarm_q && (lvl_low || lvl_high)),
    .done    (lvl_qual)
  );

  tas_qual_timer #(
    .CNT_W (32),
    .COUNT (QUAL_COUNT)
  ) u_tmp_qual (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (logo_done && !any_fault && !tmp_alarm_q && tmp_high),
    .done    (tmp_qual)
  );

  // alarm, buzzer and relay state
  logic ack_prev_q;
  logic ack_prev_d;
  logic fault_prev_q;
  logic fault_prev_d;
  logic buzzer_q;
  logic buzzer_d;
  logic lamp_q;
  logic lamp_d;
  logic alarm_relay_q;
  logic alarm_relay_d;
  logic ctrl_relay_q;
  logic ctrl_relay_d;
  logic ack_press;
  logic raise;

  // a lone press acknowledges; both held is the parameter view
  assign ack_press = ack_held && !ack_prev_q && !alt_held;
  assign raise     = (lvl_qual && !lvl_alarm_q) || (tmp_qual && !tmp_alarm_q) ||
                     (any_fault && !fault_prev_q && logo_done);

  always_comb begin
    lvl_alarm_d     = lvl_alarm_q;
    lvl_alarm_low_d = lvl_alarm_low_q;
    tmp_alarm_d     = tmp_alarm_q;
    ack_prev_d      = ack_held;
    fault_prev_d    = any_fault && logo_done;
    buzzer_d        = buzzer_q;
    ctrl_relay_d    = ctrl_relay_q;
    if (lvl_alarm_q) begin
      if (lvl_alarm_low_q) begin
        if (level_pct > thr.low_level_alarm_threshold + tas_pkg::HYST) begin
          lvl_alarm_d = 1'b0;
        end
      end else if (level_pct < thr.upper_control_threshold - tas_pkg::HYST) begin
        lvl_alarm_d = 1'b0;
      end
    end else if (lvl_qual) begin
      lvl_alarm_d     = 1'b1;
      lvl_alarm_low_d = lvl_low;
    end
    if (tmp_alarm_q) begin
      if (temp_c < thr.high_temp_alarm_threshold - tas_pkg::HYST || !is_temp) begin
        tmp_alarm_d = 1'b0;
      end
    end else if (tmp_qual) begin
      tmp_alarm_d = 1'b1;
    end
    // a new alarm or fault in the cycle of a press still sounds
    if (ack_press) begin
      buzzer_d = 1'b0;
    end
    if (raise) begin
      buzzer_d = 1'b1;
    end
    if (!lvl_alarm_d && !tmp_alarm_d && !(any_fault && logo_done)) begin
      buzzer_d = 1'b0;
    end
    lamp_d        = lvl_alarm_d || tmp_alarm_d;
    alarm_relay_d = (lvl_alarm_d || tmp_alarm_d) && !equip_err;
    // fill between the control levels with hysteresis
    if (!has_ctrl || equip_err || any_fault || !logo_done) begin
      ctrl_relay_d = 1'b0;
    end else if (level_pct <= thr.lower_control_threshold) begin
      ctrl_relay_d = 1'b1;
    end else if (level_pct >= thr.upper_control_threshold) begin
      ctrl_relay_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_alarm_q     <= 1'b0;
      lvl_alarm_low_q <= 1'b0;
      tmp_alarm_q     <= 1'b0;
      ack_prev_q      <= 1'b0;
      fault_prev_q    <= 1'b0;
      buzzer_q        <= 1'b0;
      lamp_q          <= 1'b0;
      alarm_relay_q   <= 1'b0;
      ctrl_relay_q    <= 1'b0;
    end else begin
      lvl_alarm_q     <= lvl_alarm_d;
      lvl_alarm_low_q <= lvl_alarm_low_d;
      tmp_alarm_q     <= tmp_alarm_d;
      ack_prev_q      <= ack_prev_d;
      fault_prev_q    <= fault_prev_d;
      buzzer_q        <= buzzer_d;
      lamp_q          <= lamp_d;
      alarm_relay_q   <= alarm_relay_d;
      ctrl_relay_q    <= ctrl_relay_d;
    end
  end

  // display state
  tas_pkg::tas_screen_e screen_q;
  tas_pkg::tas_screen_e screen_d;
  tas_pkg::tas_disp_s   disp_q;
  tas_pkg::tas_disp_s   disp_d;

  always_comb begin
    screen_d = screen_q;
    unique case (screen_q)
      tas_pkg::TAS_SCR_LOGO: begin
        if (logo_done) begin
          screen_d = tas_pkg::TAS_SCR_BAR;
        end
      end
      tas_pkg::TAS_SCR_BAR,
      tas_pkg::TAS_SCR_PARAM,
      tas_pkg::TAS_SCR_ERR_PROBE,
      tas_pkg::TAS_SCR_ERR_MEAS,
      tas_pkg::TAS_SCR_ERR_INT: begin
        if (ack_held && alt_held) begin
          screen_d = tas_pkg::TAS_SCR_PARAM;
        end else if (int_fault) begin
          screen_d = tas_pkg::TAS_SCR_ERR_INT;
        end else if (probe_fault) begin
          screen_d = tas_pkg::TAS_SCR_ERR_PROBE;
        end else if (range_fault) begin
          screen_d = tas_pkg::TAS_SCR_ERR_MEAS;
        end else begin
          screen_d = tas_pkg::TAS_SCR_BAR;
        end
      end
      default: screen_d = tas_pkg::TAS_SCR_LOGO;
    endcase
  end

  always_comb begin
    disp_d        = disp_q;
    disp_d.screen = screen_d;
    disp_d.mode   = mode;
    disp_d.unit_f = is_temp && unit_f;
    disp_d.arrow  = lvl_alarm_d || tmp_alarm_d;
    if (is_temp) begin
      disp_d.bar   = bar_fill(temp_c, tas_pkg::TEMP_MIN_C + tas_pkg::TEMP_BAR_STEP_C,
                              tas_pkg::TEMP_BAR_STEP_C);
      disp_d.value = unit_f ? to_fahrenheit(temp_c) : temp_c;
      disp_d.show  = tas_pkg::SHOW_TEMP_ALARM | tas_pkg::SHOW_UPPER_CTRL |
                     tas_pkg::SHOW_LOWER_CTRL;
    end else begin
      disp_d.bar   = bar_fill(level_pct, tas_pkg::BAR_BASE_PCT, tas_pkg::BAR_STEP_PCT);
      disp_d.value = level_pct;
      disp_d.show  = tas_pkg::SHOW_LOW_ALARM | tas_pkg::SHOW_HIGH_ALARM;
      if (has_ctrl) begin
        disp_d.show = disp_d.show | tas_pkg::SHOW_UPPER_CTRL | tas_pkg::SHOW_LOWER_CTRL;
      end
    end
    if (screen_d != tas_pkg::TAS_SCR_PARAM) begin
      disp_d.show = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      screen_q <= tas_pkg::TAS_SCR_LOGO;
      disp_q   <= '0;
    end else begin
      screen_q <= screen_d;
      disp_q   <= disp_d;
    end
  end

  assign disp          = disp_q;
  assign buzzer        = buzzer_q;
  assign alarm_lamp    = lamp_q;
  assign alarm_relay   = alarm_relay_q;
  assign control_relay = ctrl_relay_q;

endmodule
